// File: ssps_master.sv
`timescale 1ns/1ps
module ssps_master (
  output logic      o_sck,
  output logic      o_sel_b,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  logic b = 1'b0;
  initial o_sck = 1'b0;
  initial o_sel_b = 1'b1;
  initial o_sdi = 1'b0;
  task automatic park(input logic cpol);
    o_sck = cpol;
  endtask : park
  // Clock stands still outside frames; undriven data reads as inverse
  task automatic xfer(input logic [7:0] tx, input logic cpol, input logic cpha,
                      input int n, output logic [7:0] rx);
    o_sel_b = 1'b0;
    #200;
    for (int i = 7; i > 7 - n; i--) begin
      if (!cpha) o_sdi = tx[i];
      #40 o_sck = ~cpol;
      if (cpha) o_sdi = tx[i];
      else b = i_sdo_oe ? i_sdo : ~b;
      #40 o_sck = cpol;
      if (cpha) b = i_sdo_oe ? i_sdo : ~b;
      rx = {rx[6:0], b};
    end
    #200;
  endtask : xfer
  task automatic drop;
    o_sel_b = 1'b1;
    o_sdi = ~o_sdi;
  endtask : drop
endmodule : ssps_master

// File: ssps_monitor.sv
`timescale 1ns/1ps
module ssps_monitor (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_WR,
  input wire logic I_SEL_B,
  input wire logic I_SDO_AS_INPUT,
  input wire logic O_SDO_OE,
  input wire logic O_PORT_DONE_FLAG,
  input wire logic O_WAKE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  // Select passes a synchroniser, so five cycles leave margin
  oe_float_a: assert property (I_SEL_B [*5] |-> !O_SDO_OE)
    else $error("output driven with select high");
  pin_input_a: assert property (I_SDO_AS_INPUT [*2] |-> !O_SDO_OE)
    else $error("output driven while pin is input");
  oe_select_a: assert property ($rose(O_SDO_OE) |-> !I_SEL_B)
    else $error("output enabled without select");
  wake_flag_a: assert property ($rose(O_WAKE) |-> ##[0:2] O_PORT_DONE_FLAG)
    else $error("wake without done flag");
  wake_clear_a: assert property ($fell(O_PORT_DONE_FLAG) |-> ##[0:2] !O_WAKE)
    else $error("wake outlives done flag");
  reset_clear_a: assert property ($rose(I_RST_B) |-> !O_SDO_OE && !O_PORT_DONE_FLAG)
    else $error("outputs active after reset");
  flag_sticky_a: assert property (!I_WR [*4] ##0 O_PORT_DONE_FLAG |=> O_PORT_DONE_FLAG)
    else $error("done flag dropped without a write");
  frame_done_a: assert property ($rose(O_PORT_DONE_FLAG) |-> !I_SEL_B)
    else $error("done flag outside a frame");
  cover property ($rose(O_PORT_DONE_FLAG));
  cover property ($rose(O_SDO_OE));
  cover property ($rose(O_WAKE));
endmodule : ssps_monitor

// File: ssps_params.svh
`ifndef SSPS_PARAMS_SVH
`define SSPS_PARAMS_SVH
// Notes on behaviour
// - Eight bits shift in and out together
// - All four clock polarity/edge modes supported
// - Shift on master clock; flag at last bit
// - Select mode only when mode field is 4
// - Select low enables shifting and drives output
// - Select high floats output three core cycles later, mid-byte too
// - Port reset clears bit counter
// - Output pin as input never transmits
// - Master clocks freeze in sleep, resume
// - Idle peripheral clock may run slower
// - Done flag with enable wakes device
// - Slave receives in any power mode
// - Device reset disables port, aborts transfer
// - Sample phase bit picks sample point
`define SSPS_ADDR_BUFFER   2'h0
`define SSPS_ADDR_CONTROL  2'h1
`define SSPS_ADDR_STATUS   2'h2
`define SSPS_ADDR_FLAGS    2'h3
`define SSPS_CTL_WRITE_COLLISION      7
`define SSPS_CTL_OVF       6
`define SSPS_CTL_EN        5
`define SSPS_CTL_CKP       4
`define SSPS_STA_SMP       7
`define SSPS_STA_CKE       6
`define SSPS_STA_BF        0
`define SSPS_MODE_SLV_SEL  4'h4
`define SSPS_MODE_SLV_NSEL 4'h5
`define SSPS_BITS          4'h8
`define SSPS_RESET_BYTE    8'h00
`endif

// File: ssps_pkg.sv
package ssps_pkg;
  typedef struct packed {
    logic       clk;
    logic       sel_b;
    logic       din;
  } ssps_link_s;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssps_bus_s;
  typedef enum logic [1:0] {
    SSPS_IDLE = 2'b00,
    SSPS_SHIFT = 2'b01,
    SSPS_DONE = 2'b10
  } ssps_state_e;
endpackage : ssps_pkg

// File: ssps_port.sv
`timescale 1ns/1ps
`include "ssps_params.svh"
module ssps_port (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_B,
  input  wire logic [1:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic       I_SCK,
  input  wire logic       I_SEL_B,
  input  wire logic       I_SDI,
  input  wire logic       I_SDO_AS_INPUT,
  output logic            O_SDO,
  output logic            O_SDO_OE,
  output logic            O_PORT_DONE_FLAG,
  output logic            O_WAKE
);
  ssps_pkg::ssps_bus_s  bus;
  ssps_pkg::ssps_link_s s1_r;
  ssps_pkg::ssps_link_s s2_r;
  ssps_pkg::ssps_state_e st_r;
  logic       sck_d_r;
  logic [7:0] ctl_r;
  logic [7:0] sta_r;
  logic [7:0] buf_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic       flag_r;
  logic       irq_en_r;
  logic       smp_bit_r;
  logic       enable;
  logic       sel_mode;
  logic       port_rst;
  logic       lead_edge;
  logic       trail_edge;
  logic       samp_edge;
  logic       shift_edge;
  logic       sck_rise;
  logic       sck_fall;
  logic       done;
  logic       buf_wr;
  logic       buf_rd;
  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign enable   = ctl_r[`SSPS_CTL_EN];
  assign sel_mode = ctl_r[3:0] == `SSPS_MODE_SLV_SEL;
  assign port_rst = !enable || (sel_mode && s2_r.sel_b);
  assign sck_rise = s2_r.clk && !sck_d_r;
  assign sck_fall = !s2_r.clk && sck_d_r;
  // leading edge leaves idle level; edge-select one samples on it
  assign lead_edge  = ctl_r[`SSPS_CTL_CKP] ? sck_fall : sck_rise;
  assign trail_edge = ctl_r[`SSPS_CTL_CKP] ? sck_rise : sck_fall;
  assign shift_edge = sta_r[`SSPS_STA_CKE] ? trail_edge : lead_edge;
  assign samp_edge  = sta_r[`SSPS_STA_CKE] ? lead_edge : trail_edge;
  assign done   = samp_edge && !port_rst && cnt_r == `SSPS_BITS - 4'h1;
  assign buf_wr = bus.wr && bus.addr == `SSPS_ADDR_BUFFER;
  assign buf_rd = bus.rd && bus.addr == `SSPS_ADDR_BUFFER;
  // Pins come from the master clock domain; two flops before use
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      s1_r <= '1;
      s2_r <= '1;
      sck_d_r <= 1'b1; // Matches synchroniser reset, no false edge
    end else begin
      s1_r <= '{clk: I_SCK, sel_b: I_SEL_B, din: I_SDI};
      s2_r <= s1_r;
      sck_d_r <= s2_r.clk;
    end
  end
  // Sample phase one takes the data bit from one core cycle before the sample edge
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      smp_bit_r <= 1'b0;
    end else begin
      smp_bit_r <= sta_r[`SSPS_STA_SMP] ? s2_r.din : smp_bit_r;
    end
  end
  // Shift engine, runs without any core power gating
  // no master mode; shifting follows only the far clock
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      cnt_r <= 4'h0;
      sh_r  <= `SSPS_RESET_BYTE;
      st_r  <= ssps_pkg::SSPS_IDLE;
    end else if (port_rst) begin
      cnt_r <= 4'h0;
      st_r  <= ssps_pkg::SSPS_IDLE;
      if (buf_wr) begin
        sh_r <= bus.wdata;
      end
    end else if (buf_wr && cnt_r == 4'h0) begin
      sh_r <= bus.wdata;
    end else if (samp_edge) begin
      sh_r  <= {sh_r[6:0], sta_r[`SSPS_STA_SMP] ? smp_bit_r : s2_r.din};
      cnt_r <= done ? 4'h0 : cnt_r + 4'h1;
      st_r  <= done ? ssps_pkg::SSPS_DONE : ssps_pkg::SSPS_SHIFT;
    end else if (st_r == ssps_pkg::SSPS_DONE) begin
      st_r <= ssps_pkg::SSPS_IDLE;
    end
  end
  // Output bit changes on the shift edge; tristate on select high in select mode
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_SDO    <= 1'b0;
      O_SDO_OE <= 1'b0;
    end else begin
      O_SDO_OE <= enable && !I_SDO_AS_INPUT && !(sel_mode && s2_r.sel_b);
      if (cnt_r == 4'h0 && !shift_edge) begin
        O_SDO <= sh_r[7];
      end else if (shift_edge) begin
        O_SDO <= sh_r[7];
      end
    end
  end
  // Control register with collision and overflow flags
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      ctl_r <= `SSPS_RESET_BYTE;
    end else if (bus.wr && bus.addr == `SSPS_ADDR_CONTROL) begin
      ctl_r <= bus.wdata;
      if (done && sta_r[`SSPS_STA_BF]) begin
        ctl_r[`SSPS_CTL_OVF] <= 1'b1;
      end
    end else begin
      if (done && sta_r[`SSPS_STA_BF]) begin
        ctl_r[`SSPS_CTL_OVF] <= 1'b1;
      end
      if (buf_wr && cnt_r != 4'h0) begin
        ctl_r[`SSPS_CTL_WRITE_COLLISION] <= 1'b1;
      end
    end
  end
  // Status: sample phase and edge select writable, full flag set by hardware
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      sta_r <= `SSPS_RESET_BYTE;
    end else begin
      if (bus.wr && bus.addr == `SSPS_ADDR_STATUS) begin
        sta_r[`SSPS_STA_SMP] <= bus.wdata[`SSPS_STA_SMP];
        sta_r[`SSPS_STA_CKE] <= bus.wdata[`SSPS_STA_CKE];
      end
      if (done && !sta_r[`SSPS_STA_BF]) begin
        sta_r[`SSPS_STA_BF] <= 1'b1;
      end else if (buf_rd) begin
        sta_r[`SSPS_STA_BF] <= 1'b0;
      end
    end
  end
  // New byte is dropped if the last one was not read: overflow
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      buf_r <= `SSPS_RESET_BYTE;
    end else if (done && !sta_r[`SSPS_STA_BF]) begin
      buf_r <= {sh_r[6:0], sta_r[`SSPS_STA_SMP] ? smp_bit_r : s2_r.din};
    end
  end
  // Done flag: set wins over software clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      flag_r   <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == `SSPS_ADDR_FLAGS) begin
        irq_en_r <= bus.wdata[1];
      end
      if (done) begin
        flag_r <= 1'b1;
      end else if (bus.wr && bus.addr == `SSPS_ADDR_FLAGS && !bus.wdata[0]) begin
        flag_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_PORT_DONE_FLAG <= 1'b0;
      O_WAKE           <= 1'b0;
    end else begin
      O_PORT_DONE_FLAG <= flag_r;
      O_WAKE           <= flag_r && irq_en_r;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_RDATA <= `SSPS_RESET_BYTE;
    end else if (bus.rd) begin
      case (bus.addr)
        `SSPS_ADDR_BUFFER:  O_RDATA <= buf_r;
        `SSPS_ADDR_CONTROL: O_RDATA <= ctl_r;
        `SSPS_ADDR_STATUS:  O_RDATA <= sta_r;
        `SSPS_ADDR_FLAGS:   O_RDATA <= {6'h00, irq_en_r, flag_r};
        default:            O_RDATA <= `SSPS_RESET_BYTE;
      endcase
    end else begin
      O_RDATA <= `SSPS_RESET_BYTE;
    end
  end
endmodule : ssps_port

// File: ssps_port_tb_top.sv
`timescale 1ns/1ps
module ssps_port_tb_top;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       sdo_in = 1'b0;
  logic [7:0] rdata, rx, v;
  logic       sck, sel_b, sdi, sdo, oe, flag, wake;
  int         bad_count = 0;
  int         checks_done = 0;
  always #5 clk = ~clk;
  ssps_port DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_SCK(sck), .I_SEL_B(sel_b), .I_SDI(sdi),
    .I_SDO_AS_INPUT(sdo_in), .O_SDO(sdo), .O_SDO_OE(oe), .O_PORT_DONE_FLAG(flag), .O_WAKE(wake));
  ssps_master u_master (.o_sck(sck), .o_sel_b(sel_b), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(oe));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] s, e, input string w);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic frame(input logic [7:0] tx, input logic cpol, cpha, input int n);
    u_master.xfer(tx, cpol, cpha, n, rx);
    chk({7'h0, oe}, {7'h0, ~sdo_in}, "enable in frame");
    u_master.drop();
    repeat (6) @(posedge clk);
    chk({7'h0, oe}, 8'h00, "enable after frame");
  endtask : frame
  initial begin
    #500000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      u_master.park(k[1]);
      wreg(2'h1, 8'h00);
      wreg(2'h2, {1'b0, ~k[0], 6'h00});
      wreg(2'h3, {6'h00, k[0], 1'b0});
      wreg(2'h1, {3'h1, k[1], 4'h4});
      wreg(2'h0, 8'hA4 + k[7:0]);
      frame(8'h3C ^ k[7:0], k[1], k[0], 8);
      chk(rx, 8'hA4 + k[7:0], "slave byte");
      chk({6'h00, flag, wake}, {6'h00, 1'b1, k[0]}, "flag and wake");
      rreg(2'h2, v);
      chk({7'h0, v[0]}, 8'h01, "buffer full");
      rreg(2'h0, v);
      chk(v, 8'h3C ^ k[7:0], "buffer");
      wreg(2'h3, 8'h02);
      repeat (3) @(posedge clk);
      chk({6'h00, flag, wake}, 8'h00, "flag cleared");
    end
    u_master.park(1'b0);
    wreg(2'h1, 8'h00);
    wreg(2'h2, 8'h40);
    wreg(2'h1, 8'h24);
    wreg(2'h0, 8'hF0);
    frame(8'hFF, 1'b0, 1'b0, 4);
    chk({7'h0, flag}, 8'h00, "aborted byte");
    wreg(2'h0, 8'h96);
    frame(8'h5A, 1'b0, 1'b0, 8);
    chk(rx, 8'h96, "byte after abort");
    rreg(2'h0, v);
    chk(v, 8'h5A, "buffer after abort");
    wreg(2'h2, 8'hC0);
    rreg(2'h2, v);
    chk(v, 8'hC0, "sample phase");
    sdo_in <= 1'b1;
    frame(8'hC3, 1'b0, 1'b0, 8);
    rreg(2'h0, v);
    chk(v, 8'hC3, "receive only");
    sdo_in <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rreg(2'h1, v);
    chk(v, 8'h00, "control after reset");
    give_verdict();
  end
endmodule : ssps_port_tb_top
bind ssps_port ssps_monitor u_mon (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_WR(I_WR),
  .I_SEL_B(I_SEL_B), .I_SDO_AS_INPUT(I_SDO_AS_INPUT), .O_SDO_OE(O_SDO_OE),
  .O_PORT_DONE_FLAG(O_PORT_DONE_FLAG), .O_WAKE(O_WAKE));
